// ===== rtl/gpa_port.sv
// Summary of operation
// - Seven bits (bit 7 absent), each input or output alone
// - Direction one: driver off, pin is input
// - Direction zero: pin driven from latch bit
// - Pin register reads pins, writes latch
// - Latch register reads back latched values
// - Oscillator-owned bit six reads zero everywhere
// - Reset: bits 5,3..0 analog, bit 4 digital
// - Analog select register disables digital input
// - Analog selection leaves output drive alone
// - Bit four pin feeds timer clock input only while bit four is an input
// - Bit four pin always feeds USB receive
// - Clock-out modes drive cycle clock on six
// - Enabled peripheral takes pin from port, except bit six in clock-out modes
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module gpa_port
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic [gpa_pkg::ADDR_W-1:0] addr,
  input  wire logic [gpa_pkg::PORT_W-1:0] wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [gpa_pkg::PORT_W-1:0] rd_data,
  input  wire logic [2:0]                 osc_mode,
  input  wire logic [gpa_pkg::PORT_W-1:0] periph_claim,
  input  wire logic [gpa_pkg::PORT_W-1:0] pad_in,
  output logic      [gpa_pkg::PORT_W-1:0] pad_out,
  output logic      [gpa_pkg::PORT_W-1:0] pad_oe,
  output logic      [gpa_pkg::PORT_W-1:0] analog_select,
  output logic                            timer_zero_clock_in,
  output logic                            usb_receive_in
);

  logic [gpa_pkg::PORT_W-1:0]    dir_q;
  logic [gpa_pkg::PORT_W-1:0]    latch_q;
  logic [gpa_pkg::PORT_W-1:0]    ana_q;
  logic [gpa_pkg::CYC_CNT_W-1:0] cnt_q;
  logic [gpa_pkg::PORT_W-1:0]    pin_sync;
  logic [gpa_pkg::PORT_W-1:0]    pad_out_d;
  logic [gpa_pkg::PORT_W-1:0]    pad_oe_d;
  logic [gpa_pkg::PORT_W-1:0]    rd_data_d;

  wire logic                       bit6_io;
  wire logic                       cko_mode;
  wire logic [gpa_pkg::PORT_W-1:0] io_mask;
  wire logic [gpa_pkg::PORT_W-1:0] dig_in_mask;
  wire logic [gpa_pkg::PORT_W-1:0] pin_rd;
  wire logic                       sel_dir;
  wire logic                       sel_pin;
  wire logic                       sel_lat;
  wire logic                       sel_ana;
  wire logic                       wr_latch;

  gpa_sync u_sync
  (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (pad_in),
    .sync_out (pin_sync)
  );

  // Oscillator configuration decides who owns bit six
  assign bit6_io  = (osc_mode == gpa_pkg::OSC_EXT_CLOCK_IO_MODE)
                 || (osc_mode == gpa_pkg::OSC_EXT_CLOCK_PLL_IO_MODE)
                 || (osc_mode == gpa_pkg::OSC_INTERNAL_OSC_IO_MODE);
  assign cko_mode = (osc_mode == gpa_pkg::OSC_EXT_CLOCK_MODE)
                 || (osc_mode == gpa_pkg::OSC_EXT_CLOCK_PLL_MODE)
                 || (osc_mode == gpa_pkg::OSC_INTERNAL_CLOCK_OUT_MODE);

  assign io_mask     = gpa_pkg::FIXED_IO | {1'b0, bit6_io, 6'h00};
  assign dig_in_mask = io_mask & ~ana_q;
  assign pin_rd      = pin_sync & dig_in_mask;

  assign sel_dir  = (addr == gpa_pkg::OFS_DIR);
  assign sel_pin  = (addr == gpa_pkg::OFS_PIN);
  assign sel_lat  = (addr == gpa_pkg::OFS_LAT);
  assign sel_ana  = (addr == gpa_pkg::OFS_ANA);
  // Both the pin and latch registers write the latch
  assign wr_latch = wr_en && (sel_pin || sel_lat);

  // Unmapped offsets read as zero
  assign rd_data_d = !rd_en  ? '0
                   : sel_dir ? (dir_q & io_mask)
                   : sel_pin ? pin_rd
                   : sel_lat ? (latch_q & io_mask)
                   : sel_ana ? ana_q
                   : '0;

  genvar i;
  generate
    for (i = 0; i < gpa_pkg::PORT_W; i = i + 1)
    begin : g_pad
      if (i == gpa_pkg::OSC_BIT)
      begin : g_osc
        // Cycle clock overrides the direction bit entirely
        assign pad_out_d[i] = cko_mode ? cnt_q[gpa_pkg::CYC_CNT_W-1] : latch_q[i];
        assign pad_oe_d[i]  = cko_mode
                           || (io_mask[i] && !dir_q[i] && !periph_claim[i]);
      end
      else
      begin : g_gen
        // Analog selection plays no part in the drive
        assign pad_out_d[i] = latch_q[i];
        assign pad_oe_d[i]  = io_mask[i] && !dir_q[i] && !periph_claim[i];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dir_q   <= gpa_pkg::RST_DIR;
      latch_q <= gpa_pkg::RST_LAT;
      ana_q   <= gpa_pkg::RST_ANA;
    end
    else
    begin
      if (wr_en && sel_dir)
        dir_q <= wr_data & gpa_pkg::IMPL_MASK;
      if (wr_latch)
        latch_q <= wr_data & gpa_pkg::IMPL_MASK;
      if (wr_en && sel_ana)
        ana_q <= wr_data & gpa_pkg::ANA_MASK;
    end
  end

  // Free-running divider; duty cycle stays at one half
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  // Registered pads avoid glitches from the decode
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pad_out <= '0;
      pad_oe  <= '0;
    end
    else
    begin
      pad_out <= pad_out_d;
      pad_oe  <= pad_oe_d;
    end
  end

  // Read data stands for exactly one cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      rd_data <= '0;
    else
      rd_data <= rd_data_d;
  end

  // Alternate inputs use the synchronised level, never the raw pad
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      timer_zero_clock_in <= 1'b0;
      usb_receive_in      <= 1'b0;
    end
    else
    begin
      timer_zero_clock_in <= pin_sync[gpa_pkg::TMR_BIT] && dir_q[gpa_pkg::TMR_BIT];
      usb_receive_in      <= pin_sync[gpa_pkg::TMR_BIT];
    end
  end

  assign analog_select = ana_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_INPUT_HIZ: assert property (dir_q[0] |=> !pad_oe[0])
    else $error("Input bit still driven");

  AST_OUTPUT_DRIVE: assert property (
    (!dir_q[1] && !periph_claim[1]) |=> (pad_oe[1] && (pad_out[1] == $past(latch_q[1]))))
    else $error("Output bit not driven from latch");

  AST_PIN_WRITE: assert property (
    (wr_en && sel_pin) |=> (latch_q[5:0] == $past(wr_data[5:0])) ##1
    (pad_out[5:0] == $past(latch_q[5:0])))
    else $error("Pin register write missed latch");

  // Back-to-back reads are legal, so the idle zero only follows a gap
  AST_LATCH_READ: assert property (
    (rd_en && sel_lat) |=> (rd_data[5:0] == $past(latch_q[5:0])) ##1
    ($past(rd_en) || (rd_data == '0)))
    else $error("Latch readback wrong");

  AST_OSC_ZERO: assert property (
    (rd_en && !bit6_io) |=> (rd_data[gpa_pkg::OSC_BIT] == 1'b0))
    else $error("Oscillator bit not reading zero");

  AST_ANALOG_READ_ZERO: assert property (
    (rd_en && sel_pin && ana_q[0]) |=> (rd_data[0] == 1'b0))
    else $error("Analog pin read digital level");

  AST_ANALOG_DRIVE: assert property (
    (ana_q[2] && !dir_q[2] && !periph_claim[2]) |=> pad_oe[2])
    else $error("Analog selection dropped drive");

  AST_TIMER_FEED: assert property (
    !dir_q[gpa_pkg::TMR_BIT] |=> !timer_zero_clock_in)
    else $error("Timer clock fed by output pin");

  AST_USB_RX: assert property (
    usb_receive_in == $past(pin_sync[gpa_pkg::TMR_BIT]))
    else $error("USB receive not following pin");

  AST_CYCLE_CLOCK: assert property (
    cko_mode [*5] |-> (pad_out[gpa_pkg::OSC_BIT] != $past(pad_out[gpa_pkg::OSC_BIT], 2))
    && pad_oe[gpa_pkg::OSC_BIT])
    else $error("Cycle clock not at quarter rate");

  AST_CLAIM: assert property (periph_claim[3] |=> !pad_oe[3])
    else $error("Claimed pin still driven by port");

  AST_SYNC: assert property (
    ($past(rst_n) && $past(rst_n, 2)) |-> (pin_sync == $past(pad_in, 2)))
    else $error("Pin levels not two stages late");

  // Reset values still stand at the first edge after release
  AST_RESET_REGS: assert property (
    !$past(rst_n) |-> ((dir_q == gpa_pkg::RST_DIR) && (latch_q == gpa_pkg::RST_LAT)
    && (ana_q == gpa_pkg::RST_ANA)))
    else $error("Registers not at reset values");

  AST_RESET_PADS: assert property (
    !$past(rst_n) |-> ((pad_oe == 8'h00) && (rd_data == 8'h00)))
    else $error("Pads or read data active out of reset");

  AST_RD_IDLE: assert property (
    !rd_en |=> (rd_data == 8'h00))
    else $error("Read data not zero without a read");

  AST_DIR_WRITE: assert property (
    (wr_en && sel_dir) |=> (dir_q == {1'b0, $past(wr_data[6:0])}))
    else $error("Direction write not stored");

  AST_DIR_HOLD: assert property (
    !(wr_en && sel_dir) |=> $stable(dir_q))
    else $error("Direction changed without a write");

  AST_DIR_READ: assert property (
    (rd_en && sel_dir && bit6_io) |=> (rd_data == {1'b0, $past(dir_q[6:0])}))
    else $error("Direction readback wrong");

  AST_LATCH_WRITE: assert property (
    (wr_en && sel_lat) |=> (latch_q == {1'b0, $past(wr_data[6:0])}))
    else $error("Latch write not stored");

  AST_LATCH_HOLD: assert property (
    !(wr_en && (sel_pin || sel_lat)) |=> $stable(latch_q))
    else $error("Latch changed without a write");

  AST_ANA_WRITE: assert property (
    (wr_en && sel_ana) |=> (ana_q == ($past(wr_data) & gpa_pkg::ANA_MASK)))
    else $error("Analog select write wrong");

  AST_ANA_RANGE: assert property (
    ((analog_select & ~gpa_pkg::ANA_MASK) == 8'h00))
    else $error("Analog select on a digital-only bit");

  AST_PIN_READ: assert property (
    (rd_en && sel_pin) |=> (rd_data[gpa_pkg::TMR_BIT] == $past(pin_sync[gpa_pkg::TMR_BIT])))
    else $error("Pin read not from synchronised level");

  // Bit six belongs to the oscillator unless an I/O mode frees it
  AST_OSC_OFF: assert property (
    (!bit6_io && !cko_mode) |=> !pad_oe[gpa_pkg::OSC_BIT])
    else $error("Oscillator-owned bit driven by port");

  AST_OSC_LATCH_READ: assert property (
    (rd_en && sel_lat && bit6_io) |=> (rd_data[gpa_pkg::OSC_BIT] == $past(latch_q[6])))
    else $error("Bit six latch not read back in I/O mode");

  AST_IO6_DRIVE: assert property (
    (bit6_io && !dir_q[6] && !periph_claim[6])
    |=> (pad_oe[gpa_pkg::OSC_BIT] && (pad_out[gpa_pkg::OSC_BIT] == $past(latch_q[6]))))
    else $error("Bit six not driven from latch");

  AST_CKO_DRIVE: assert property (
    cko_mode |=> pad_oe[gpa_pkg::OSC_BIT])
    else $error("Cycle clock pin not driven");

  AST_TIMER_INPUT: assert property (
    dir_q[gpa_pkg::TMR_BIT] |=> (timer_zero_clock_in == $past(pin_sync[gpa_pkg::TMR_BIT])))
    else $error("Timer clock not following input pin");

  // Claimed pins stay off even when the direction bit says output
  AST_CLAIM_ALL: assert property (
    (|periph_claim[5:0]) |=> ((pad_oe[5:0] & $past(periph_claim[5:0])) == 6'h00))
    else $error("Claimed pin driven by port");

endmodule : gpa_port

// ===== rtl/gpa_sync.sv
`timescale 1ns/10ps
module gpa_sync
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic [gpa_pkg::PORT_W-1:0] async_in,
  output logic      [gpa_pkg::PORT_W-1:0] sync_out
);

  logic [gpa_pkg::PORT_W-1:0] meta_q;

  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < gpa_pkg::PORT_W; i = i + 1)
    begin : g_bit
      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          meta_q[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule : gpa_sync

// ===== shared/gpa_pkg.sv
package gpa_pkg;

  localparam int ADDR_W = 3;
  localparam int PORT_W = 8;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFS_DIR = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_PIN = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_LAT = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_ANA = 3'h3;

  // Implemented bits; bit 7 is absent and reads as zero
  localparam logic [PORT_W-1:0] IMPL_MASK = 8'h7f;
  // Bits that may be analog inputs: 5 and 3..0
  localparam logic [PORT_W-1:0] ANA_MASK  = 8'h2f;
  // Bits always usable as plain I/O, whatever the oscillator mode
  localparam logic [PORT_W-1:0] FIXED_IO  = 8'h3f;

  localparam logic [PORT_W-1:0] RST_DIR = 8'h7f;
  localparam logic [PORT_W-1:0] RST_LAT = 8'h00;
  localparam logic [PORT_W-1:0] RST_ANA = 8'h2f;

  localparam int OSC_BIT = 6;
  localparam int TMR_BIT = 4;

  // Cycle clock is the oscillator divided by four
  localparam int CYC_DIV   = 4;
  localparam int CYC_CNT_W = $clog2(CYC_DIV);

  typedef enum logic [2:0] {
    OSC_XTAL_MODE              = 3'b000,
    OSC_EXT_CLOCK_MODE         = 3'b001,
    OSC_EXT_CLOCK_IO_MODE      = 3'b010,
    OSC_EXT_CLOCK_PLL_MODE     = 3'b011,
    OSC_EXT_CLOCK_PLL_IO_MODE  = 3'b100,
    OSC_INTERNAL_CLOCK_OUT_MODE = 3'b101,
    OSC_INTERNAL_OSC_IO_MODE   = 3'b110
  } gpa_osc_mode_t;

endpackage : gpa_pkg

// ===== tb/gpa_pin_model.sv
`timescale 1ns/10ps
module gpa_pin_model
(
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  input  wire logic       sys_clk,
  output logic      [7:0] pad_in
);
  logic [7:0] float_q = 8'h00;
  // Undriven pins wander so a stale level never passes for a drive
  always_ff @(posedge sys_clk) float_q <= ~float_q;
  // Port driver wins; board drive only where the port is off
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & float_q);
endmodule : gpa_pin_model

// ===== tb/gpa_port_tb_top.sv
`timescale 1ns/10ps
module gpa_port_tb_top;
  logic       sys_clk      = 1'b0;
  logic       rst_n        = 1'b0;
  logic [2:0] addr         = 3'h0;
  logic [7:0] wr_data      = 8'h00;
  logic       wr_en        = 1'b0;
  logic       rd_en        = 1'b0;
  logic [2:0] osc_mode     = 3'h2;
  logic [7:0] periph_claim = 8'h00;
  logic [7:0] ext_val      = 8'h3a;
  logic [7:0] ext_en       = 8'hff;
  logic [7:0] rd_data, pad_in, pad_out, pad_oe, analog_select, v;
  logic       tmr_clk, usb_rcv, io, ck;
  int         n_mismatch   = 0;
  int         compares     = 0;
  int         cycles       = 0;

  gpa_port gpa_port_inst (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .osc_mode(osc_mode),
    .periph_claim(periph_claim), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .analog_select(analog_select), .timer_zero_clock_in(tmr_clk), .usb_receive_in(usb_rcv));
  gpa_pin_model gpa_pin_model_inst (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
    .ext_en(ext_en), .sys_clk(sys_clk), .pad_in(pad_in));

  always #20 sys_clk = ~sys_clk;

  task automatic final_report();
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 check(rd_data, exp);
  endtask : rd

  // Covers register update, drive update and the pin synchroniser
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(gpa_pkg::OFS_DIR, 8'h7f);
    rd(gpa_pkg::OFS_LAT, 8'h00);
    rd(gpa_pkg::OFS_ANA, 8'h2f);
    rd(gpa_pkg::OFS_PIN, 8'h10);
    rd(3'h5, 8'h00);
    wr(gpa_pkg::OFS_PIN, 8'h55);
    wr(gpa_pkg::OFS_DIR, 8'h00);
    settle();
    check(pad_oe, 8'h7f);
    check(pad_out, 8'h55);
    check({7'h0, tmr_clk}, 8'h00);
    check({7'h0, usb_rcv}, 8'h01);
    rd(gpa_pkg::OFS_LAT, 8'h55);
    rd(gpa_pkg::OFS_PIN, 8'h50);
    wr(gpa_pkg::OFS_ANA, 8'h00);
    wr(gpa_pkg::OFS_LAT, 8'h4f);
    settle();
    rd(gpa_pkg::OFS_PIN, 8'h4f);
    check({7'h0, usb_rcv}, 8'h00);
    wr(gpa_pkg::OFS_DIR, 8'hff);
    settle();
    check(pad_oe, 8'h00);
    rd(gpa_pkg::OFS_PIN, 8'h3a);
    rd(gpa_pkg::OFS_LAT, 8'h4f);
    check({7'h0, tmr_clk}, 8'h01);
    wr(gpa_pkg::OFS_ANA, 8'hff);
    rd(gpa_pkg::OFS_ANA, 8'h2f);
    check(analog_select, 8'h2f);
    for (int m = 0; m < 7; m++)
    begin
      @(posedge sys_clk);
      osc_mode <= 3'(m);
      ext_val  <= 8'h7a;
      io = (m == 2) || (m == 4) || (m == 6);
      ck = (m == 1) || (m == 3) || (m == 5);
      settle();
      rd(gpa_pkg::OFS_DIR, io ? 8'h7f : 8'h3f);
      rd(gpa_pkg::OFS_LAT, io ? 8'h4f : 8'h0f);
      rd(gpa_pkg::OFS_PIN, io ? 8'h50 : 8'h10);
      for (int i = 0; i < 8; i++)
      begin
        @(posedge sys_clk);
        #1 v[i] = pad_out[6];
      end
      check({7'h0, pad_oe[6]}, {7'h0, ck});
      if (ck)
        check((v ^ (v >> 2)) & 8'h3f, 8'h3f);
    end
    wr(gpa_pkg::OFS_DIR, 8'h00);
    @(posedge sys_clk);
    periph_claim <= 8'h0f;
    settle();
    check(pad_oe, 8'h70);
    // Second reset in mid-run must restore every default
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(gpa_pkg::OFS_DIR, 8'h7f);
    rd(gpa_pkg::OFS_LAT, 8'h00);
    rd(gpa_pkg::OFS_ANA, 8'h2f);
    check(pad_oe, 8'h00);
    final_report();
  end
endmodule : gpa_port_tb_top
